/* File: verilog/vip_unit.sv */
// top of the vectored interrupt priority unit with avalon registers
// Contract
// - all peripheral requests merge into one request to the core
// - default vector table starts at program address 000004h
// - table holds 126 entries: 8 trap entries then 118 interrupts
// - each entry holds a 24-bit handler start address
// - equal standing: lower vector address wins, vector 0 beats all
// - seven software priority levels per source, ties by natural order
// - fixed ordering among sources sharing one priority level
// - up to 61 interrupt sources and 5 traps, each own vector
// - alternate select bit 15 of control two redirects every fetch
// - alternate table follows default table with identical layout
// - entry and return latency fixed, independent of source
// - reset bypasses arbitration, clears control, enable, status and mask registers, sets priorities to 4, program counter zero
// - enable group 3: bit13 dma5 done, bit8 can two, rest zero
// - enable one passes a request to arbitration, zero blocks it
module vip_unit (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWritedata,
    input wire logic [3:0] avsByteenable,
    output logic [31:0] avsReaddata,
    output logic avsWaitrequest,
    input wire logic [vip_pkg::NUM_SLOT-1:0] irqIn,
    input wire logic [vip_pkg::NUM_TRAP-1:0] trapIn,
    input wire logic [2:0] coreIpl,
    input wire logic coreAck,
    output logic coreIrqReq,
    output logic coreIsTrap,
    output logic [6:0] coreVector,
    output logic [23:0] coreEntryAddr,
    output logic pcForceZero,
    output logic irqOut
);

    // ========================================================
    // registers
    vip_pkg::vip_bus_e busState;
    logic [15:0] ctrl;
    logic [15:0] enGroup [4];
    logic [2:0] prio [vip_pkg::NUM_SLOT];
    logic [vip_pkg::ST_WIDTH-1:0] status;
    logic [vip_pkg::ST_WIDTH-1:0] mask;

    // ========================================================
    // bus decode
    logic busReq;
    logic busWr;
    logic [15:0] laneMask;
    logic [15:0] wrData;
    logic hitCtrl;
    logic hitStatus;
    logic hitMask;
    logic hitEn;
    logic hitPrio;
    logic [1:0] enIdx;
    logic [3:0] prioIdx;
    logic [31:0] next_readdata;

    assign busReq = avsRead || avsWrite;
    // a write lands only at the edge where waitrequest is seen low
    assign busWr = avsWrite && busState == vip_pkg::VIP_BUS_DONE;
    assign laneMask = {{8{avsByteenable[1]}}, {8{avsByteenable[0]}}};
    assign wrData = avsWritedata[15:0] & laneMask;
    assign hitCtrl = avsAddress[7:2] == vip_pkg::OFS_CTRL[7:2];
    assign hitStatus = avsAddress[7:2] == vip_pkg::OFS_STATUS[7:2];
    assign hitMask = avsAddress[7:2] == vip_pkg::OFS_MASK[7:2];
    assign hitEn = avsAddress >= vip_pkg::OFS_EN0 &&
        avsAddress <= vip_pkg::OFS_EN3 + 8'h03;
    assign hitPrio = avsAddress >= vip_pkg::OFS_PRIO0 &&
        avsAddress <= vip_pkg::OFS_PRIO15 + 8'h03;
    assign enIdx = 2'(avsAddress[7:2] - vip_pkg::OFS_EN0[7:2]);
    assign prioIdx = 4'(avsAddress[7:2] - vip_pkg::OFS_PRIO0[7:2]);

    // ========================================================
    // arbitration
    logic [vip_pkg::NUM_SLOT-1:0] srcEn;
    logic [vip_pkg::NUM_SLOT-1:0] pending;
    logic winHit;
    logic winTrap;
    logic [6:0] winVector;
    logic [23:0] winAddr;
    logic altSel;

    assign srcEn = {enGroup[3], enGroup[2], enGroup[1], enGroup[0]};
    assign pending = irqIn & srcEn;
    assign altSel = ctrl[vip_pkg::ALT_SEL_BIT];

    vip_arbiter arb (
        .pending(pending),
        .prio(prio),
        .trapIn(trapIn),
        .coreIpl(coreIpl),
        .hit(winHit),
        .isTrap(winTrap),
        .vector(winVector)
    );

    vip_vector_addr vaddr (
        .vector(winVector),
        .altSel(altSel),
        .entryAddr(winAddr)
    );

    // ========================================================
    // read mux
    logic [15:0] prioWord;

    assign prioWord = {1'b0, prio[{prioIdx, 2'd3}],
        1'b0, prio[{prioIdx, 2'd2}],
        1'b0, prio[{prioIdx, 2'd1}],
        1'b0, prio[{prioIdx, 2'd0}]};

    always_comb begin
        next_readdata = 32'h00000000;
        if (hitCtrl) begin
            next_readdata = {16'h0000, ctrl};
        end else if (hitStatus) begin
            next_readdata = {30'h00000000, status};
        end else if (hitMask) begin
            next_readdata = {30'h00000000, mask};
        end else if (hitEn) begin
            next_readdata = {16'h0000, enGroup[enIdx]};
        end else if (hitPrio) begin
            next_readdata = {16'h0000, prioWord};
        end else if (avsAddress[7:2] == vip_pkg::OFS_WINNER[7:2]) begin
            next_readdata = {24'h000000, winHit, winVector};
        end
    end

    // ========================================================
    // avalon handshake: one wait cycle, then the answer
    always_ff @(posedge clock) begin
        if (rst) begin
            busState <= vip_pkg::VIP_BUS_IDLE;
            avsWaitrequest <= 1'b1;
            avsReaddata <= 32'h00000000;
        end else begin
            case (busState)
                vip_pkg::VIP_BUS_IDLE: begin
                    if (busReq) begin
                        busState <= vip_pkg::VIP_BUS_DONE;
                        avsWaitrequest <= 1'b0;
                        avsReaddata <= next_readdata;
                    end
                end
                default: begin
                    busState <= vip_pkg::VIP_BUS_IDLE;
                    avsWaitrequest <= 1'b1;
                end
            endcase
        end
    end

    // ========================================================
    // control, enables and priorities
    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl <= vip_pkg::CTRL_RST;
        end else if (busWr && hitCtrl) begin
            ctrl <= (ctrl & ~laneMask) | wrData;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gen_en
            localparam logic [15:0] IMPL =
                (g == 3) ? vip_pkg::EN3_IMPL : vip_pkg::EN_FULL;
            always_ff @(posedge clock) begin
                if (rst) begin
                    enGroup[g] <= vip_pkg::EN_RST;
                end else if (busWr && hitEn && enIdx == 2'(g)) begin
                    // absent bits stay zero
                    enGroup[g] <= ((enGroup[g] & ~laneMask) | wrData)
                        & IMPL;
                end
            end
        end
        for (g = 0; g < vip_pkg::NUM_SLOT; g++) begin : gen_prio
            localparam int unsigned FB = (g % 4) * 4;
            always_ff @(posedge clock) begin
                if (rst) begin
                    prio[g] <= vip_pkg::PRIO_RST;
                end else if (busWr && hitPrio && prioIdx == 4'(g / 4)
                    && laneMask[FB]) begin
                    prio[g] <= avsWritedata[FB+:3];
                end
            end
        end
    endgenerate

    // ========================================================
    // events, status and interrupt line
    logic [vip_pkg::ST_WIDTH-1:0] events;
    logic [vip_pkg::ST_WIDTH-1:0] clearBits;
    logic [vip_pkg::ST_WIDTH-1:0] next_status;

    assign events[vip_pkg::ST_IRQ_TAKEN] =
        coreAck && coreIrqReq && !coreIsTrap;
    assign events[vip_pkg::ST_TRAP_TAKEN] =
        coreAck && coreIrqReq && coreIsTrap;
    assign clearBits = (busWr && hitStatus && avsByteenable[0]) ?
        avsWritedata[vip_pkg::ST_WIDTH-1:0] : 2'h0;
    // a new event beats a clear in the same cycle
    assign next_status = (status & ~clearBits) | events;

    always_ff @(posedge clock) begin
        if (rst) begin
            status <= vip_pkg::STATUS_RST;
            mask <= vip_pkg::MASK_RST;
            irqOut <= 1'b0;
        end else begin
            status <= next_status;
            if (busWr && hitMask && avsByteenable[0]) begin
                mask <= avsWritedata[vip_pkg::ST_WIDTH-1:0];
            end
            irqOut <= |(status & mask);
        end
    end

    // ========================================================
    // core side
    // registered every cycle, so the delay is the same for any source
    always_ff @(posedge clock) begin
        if (rst) begin
            coreIrqReq <= 1'b0;
            coreIsTrap <= 1'b0;
            coreVector <= 7'h00;
            coreEntryAddr <= vip_pkg::RESET_PC;
            pcForceZero <= 1'b1;
        end else begin
            coreIrqReq <= winHit;
            coreIsTrap <= winTrap;
            coreVector <= winVector;
            coreEntryAddr <= winAddr;
            pcForceZero <= 1'b0;
        end
    end

    // ========================================================
    // checks
    sequence busAsked;
        busReq && avsWaitrequest;
    endsequence
    sequence busAnswered;
        !avsWaitrequest ##1 avsWaitrequest;
    endsequence

    bus_answer_a: assert property (@(posedge clock) disable iff (rst)
        busAsked |=> busAnswered)
        else $error("bus answer not given in one cycle");
    single_req_a: assert property (@(posedge clock) disable iff (rst)
        !$past(rst) |-> coreIrqReq == $past(winHit))
        else $error("core request not one cycle after winner");
    default_base_a: assert property (@(posedge clock) disable iff (rst)
        coreIrqReq && !$past(altSel) |-> coreEntryAddr ==
        24'(vip_pkg::DEF_TABLE_BASE + {coreVector, 1'b0}))
        else $error("default entry address wrong");
    vector_range_a: assert property (@(posedge clock) disable iff (rst)
        coreIrqReq |-> coreVector <= vip_pkg::LAST_VECTOR)
        else $error("vector beyond table");
    alt_table_a: assert property (@(posedge clock) disable iff (rst)
        coreIrqReq && $past(altSel) |-> coreEntryAddr ==
        24'(vip_pkg::ALT_TABLE_BASE + {coreVector, 1'b0}))
        else $error("alternate entry address wrong");
    trap_first_a: assert property (@(posedge clock) disable iff (rst)
        |trapIn |=> coreIrqReq && coreIsTrap)
        else $error("trap did not win");
    enable_gate_a: assert property (@(posedge clock) disable iff (rst)
        coreIrqReq && !coreIsTrap |->
        $past(srcEn[6'(winVector - vip_pkg::TRAP_OFFSET)]))
        else $error("disabled source reached the core");
    level_above_a: assert property (@(posedge clock) disable iff (rst)
        coreIrqReq && !coreIsTrap |->
        $past(prio[6'(winVector - vip_pkg::TRAP_OFFSET)]) >
        $past(coreIpl))
        else $error("winner level not above core level");
    en3_zero_a: assert property (@(posedge clock) disable iff (rst)
        (enGroup[3] & ~vip_pkg::EN3_IMPL) == 16'h0000)
        else $error("absent enable bit set");
    reset_pc_a: assert property (@(posedge clock)
        rst |=> pcForceZero && !coreIrqReq &&
        enGroup[3] == vip_pkg::EN_RST)
        else $error("reset did not clear and force pc");
    sticky_set_a: assert property (@(posedge clock) disable iff (rst)
        |events |=> (status & $past(events)) == $past(events))
        else $error("event lost against clear");

endmodule // vip_unit

/* File: include/vip_pkg.sv */
// shared constants and types for the vectored interrupt priority unit
package vip_pkg;

    // ========================================================
    // source counts and vector table layout
    localparam int unsigned NUM_SLOT = 64;
    localparam int unsigned NUM_TRAP = 5;
    localparam int unsigned TRAP_SLOTS = 8;
    localparam int unsigned IRQ_ENTRIES = 118;
    localparam int unsigned TABLE_ENTRIES = 126;
    localparam int unsigned MAX_IRQ = 61;
    localparam logic [23:0] DEF_TABLE_BASE = 24'h000004;
    localparam logic [23:0] ENTRY_STEP = 24'h000002;
    localparam logic [23:0] ALT_TABLE_BASE =
        24'(DEF_TABLE_BASE + 24'(TABLE_ENTRIES) * ENTRY_STEP);
    localparam logic [23:0] RESET_PC = 24'h000000;
    localparam logic [6:0] TRAP_OFFSET = 7'h08;
    localparam logic [6:0] LAST_VECTOR = 7'h7d;

    // ========================================================
    // priority levels
    localparam logic [2:0] PRIO_OFF = 3'h0;
    localparam logic [2:0] PRIO_RST = 3'h4;

    // ========================================================
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_EN0 = 8'h0c;
    localparam logic [7:0] OFS_EN3 = 8'h18;
    localparam logic [7:0] OFS_PRIO0 = 8'h20;
    localparam logic [7:0] OFS_PRIO15 = 8'h5c;
    localparam logic [7:0] OFS_WINNER = 8'h60;

    // ========================================================
    // fields and reset values
    localparam int unsigned ALT_SEL_BIT = 15;
    localparam int unsigned ST_IRQ_TAKEN = 0;
    localparam int unsigned ST_TRAP_TAKEN = 1;
    localparam int unsigned ST_WIDTH = 2;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] EN_RST = 16'h0000;
    localparam logic [ST_WIDTH-1:0] STATUS_RST = 2'h0;
    localparam logic [ST_WIDTH-1:0] MASK_RST = 2'h0;
    // only the dma channel 5 done (13) and second can (8) bits exist
    localparam logic [15:0] EN3_IMPL = 16'h2100;
    localparam logic [15:0] EN_FULL = 16'hffff;
    localparam int unsigned ENTRY_LATENCY = 1;

    // ========================================================
    // register bus handshake states
    typedef enum logic [1:0] {
        VIP_BUS_IDLE = 2'b01,
        VIP_BUS_DONE = 2'b10
    } vip_bus_e;

endpackage

/* File: verilog/vip_arbiter.sv */
// priority arbiter: traps first, then level, then natural order
module vip_arbiter (
    input wire logic [vip_pkg::NUM_SLOT-1:0] pending,
    input wire logic [2:0] prio [vip_pkg::NUM_SLOT],
    input wire logic [vip_pkg::NUM_TRAP-1:0] trapIn,
    input wire logic [2:0] coreIpl,
    output logic hit,
    output logic isTrap,
    output logic [6:0] vector
);

    // ========================================================
    // search
    logic [2:0] bestPrio;
    logic [5:0] bestSlot;
    logic [2:0] trapSlot;
    logic irqHit;

    always_comb begin
        bestPrio = vip_pkg::PRIO_OFF;
        bestSlot = 6'h00;
        trapSlot = 3'h0;
        // descending scan with >= leaves the lowest index on ties
        for (int i = vip_pkg::NUM_SLOT - 1; i >= 0; i--) begin
            if (pending[i] && prio[i] >= bestPrio &&
                prio[i] != vip_pkg::PRIO_OFF) begin
                bestPrio = prio[i];
                bestSlot = 6'(i);
            end
        end
        for (int t = vip_pkg::NUM_TRAP - 1; t >= 0; t--) begin
            if (trapIn[t]) begin
                trapSlot = 3'(t);
            end
        end
    end

    // only a level above the core's own may interrupt it
    assign irqHit = bestPrio > coreIpl;
    // traps ignore enables and the core level
    assign isTrap = |trapIn;
    assign hit = isTrap || irqHit;
    assign vector = isTrap ? {4'h0, trapSlot} :
        7'(vip_pkg::TRAP_OFFSET + {1'b0, bestSlot});

endmodule // vip_arbiter

/* File: verilog/vip_vector_addr.sv */
// entry address of a vector in the default or alternate table
module vip_vector_addr (
    input wire logic [6:0] vector,
    input wire logic altSel,
    output logic [23:0] entryAddr
);

    // ========================================================
    // address
    logic [23:0] tableBase;
    logic [23:0] entryOffset;

    // alternate table follows the default one with the same layout
    assign tableBase = altSel ? vip_pkg::ALT_TABLE_BASE :
        vip_pkg::DEF_TABLE_BASE;
    // each entry holds one 24-bit handler address
    assign entryOffset = 24'({17'h00000, vector} *
        vip_pkg::ENTRY_STEP);
    assign entryAddr = 24'(tableBase + entryOffset);

endmodule // vip_vector_addr

/* File: testbench/vip_core_model.sv */
// processor core model: takes the merged request and pulses acknowledge
module vip_core_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic coreIrqReq,
    input wire logic ackOn,
    input wire logic [1:0] ackWait,
    output logic coreAck
);
    timeunit 1ns;
    timeprecision 100ps;
    // ====================================================
    // acknowledge timing
    // the core only sees one request line, never the sources
    logic [1:0] waitCount;
    // ackWait lets the bench play a prompt or a slow core
    always_ff @(posedge clock) begin
        if (rst) begin
            coreAck <= 1'b0;
            waitCount <= 2'h0;
        end else if (coreAck) begin
            coreAck <= 1'b0;
            waitCount <= 2'h0;
        end else if (ackOn && coreIrqReq) begin
            if (waitCount == ackWait) begin
                coreAck <= 1'b1;
            end else begin
                waitCount <= waitCount + 2'h1;
            end
        end else begin
            waitCount <= 2'h0;
        end
    end
endmodule // vip_core_model

/* File: testbench/tb.sv */
// self-checking bench for the vectored interrupt priority unit
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    // ====================================================
    // signals
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] avsAddress = 8'h00;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWritedata = 32'h0;
    logic [3:0] avsByteenable = 4'h3;
    logic [31:0] avsReaddata;
    logic avsWaitrequest;
    logic [63:0] irqIn = 64'h0;
    logic [4:0] trapIn = 5'h00;
    logic [2:0] coreIpl = 3'h0;
    logic coreAck;
    logic coreIrqReq;
    logic coreIsTrap;
    logic [6:0] coreVector;
    logic [23:0] coreEntryAddr;
    logic pcForceZero;
    logic irqOut;
    logic ackOn = 1'b0;
    logic [1:0] ackWait = 2'h0;
    int mismatches = 0;
    int checksDone = 0;
    int seed = 17229;
    logic [2:0] prioM [64];
    logic [63:0] enM;
    logic altM;

    vip_unit i_vip_unit (.clock(clock), .rst(rst), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
        .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
        .avsWaitrequest(avsWaitrequest), .irqIn(irqIn), .trapIn(trapIn),
        .coreIpl(coreIpl), .coreAck(coreAck), .coreIrqReq(coreIrqReq),
        .coreIsTrap(coreIsTrap), .coreVector(coreVector),
        .coreEntryAddr(coreEntryAddr), .pcForceZero(pcForceZero),
        .irqOut(irqOut));
    vip_core_model i_vip_core_model (.clock(clock), .rst(rst),
        .coreIrqReq(coreIrqReq), .ackOn(ackOn), .ackWait(ackWait),
        .coreAck(coreAck));

    always #50 clock = ~clock;

    // ====================================================
    // helpers
    task automatic check(input logic [32:0] got, input logic [32:0] exp,
                         input string what);
        checksDone++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t ns: %s got %h expected %h", $time, what,
                     got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checksDone, mismatches);
        if (mismatches == 0 && checksDone > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // request held until waitrequest is sampled low, no cycle count assumed
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [15:0] d, output logic [31:0] got);
        int n;
        n = 0;
        @(posedge clock);
        avsAddress <= a;
        avsWritedata <= {16'h0, d};
        avsWrite <= wr;
        avsRead <= !wr;
        @(posedge clock);
        while (avsWaitrequest !== 1'b0 && n < 50) begin
            @(posedge clock);
            n++;
        end
        got = avsReaddata;
        if (n >= 50) begin
            mismatches++;
            $display("Error at %0t ns: bus answer missing", $time);
        end
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [15:0] e,
                       input string w);
        logic [31:0] x;
        bus(1'b0, a, 16'h0, x);
        check({1'b0, x}, {17'h0, e}, w);
    endtask

    task automatic do_reset();
        @(posedge clock);
        rst <= 1'b1;
        repeat (8) @(posedge clock);
        @(negedge clock);
        check({32'h0, pcForceZero}, 33'h1, "pc held at zero");
        check({32'h0, coreIrqReq}, 33'h0, "request in reset");
        @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        @(negedge clock);
        check({32'h0, pcForceZero}, 33'h0, "pc released");
    endtask

    task automatic wait_irq(input logic lvl, input string w);
        int n;
        n = 0;
        while (irqOut !== lvl && n < 20) begin
            @(negedge clock);
            n++;
        end
        check({32'h0, irqOut}, {32'h0, lvl}, w);
    endtask

    // reference arbiter: traps, then level above core, then lowest slot
    function automatic logic [32:0] expect_core(input logic [63:0] irq,
            input logic [4:0] trap, input logic [2:0] ipl);
        logic [2:0] best;
        logic [6:0] v;
        logic t;
        logic [23:0] base;
        best = 3'h0;
        v = 7'h0;
        t = 1'b0;
        base = vip_pkg::DEF_TABLE_BASE;
        if (altM) begin
            base = base + 24'(vip_pkg::TABLE_ENTRIES) * 24'h2;
        end
        for (int i = 4; i >= 0; i--) begin
            if (trap[i]) begin
                t = 1'b1;
                v = 7'(i);
            end
        end
        for (int i = 63; i >= 0; i--) begin
            if (!t && irq[i] && enM[i] && prioM[i] > ipl
                && prioM[i] >= best) begin
                best = prioM[i];
                v = 7'(8 + i);
            end
        end
        if (!t && best == 3'h0) begin
            return 33'h0;
        end
        return {1'b1, t, v, base + 24'(v) * 24'h2};
    endfunction

    // outputs are registered: exactly one edge from cause to answer
    task automatic apply(input logic [63:0] irq, input logic [4:0] trap,
                         input logic [2:0] ipl, input string w);
        logic [32:0] e;
        e = expect_core(irq, trap, ipl);
        @(posedge clock);
        irqIn <= irq;
        trapIn <= trap;
        coreIpl <= ipl;
        @(posedge clock);
        @(negedge clock);
        check({coreIrqReq, e[32] ? {coreIsTrap, coreVector, coreEntryAddr}
               : 32'h0}, e, w);
    endtask

    task automatic program_all();
        logic [15:0] w;
        for (int p = 0; p < 16; p++) begin
            w = 16'($random(seed)) & 16'h7777;
            wr(8'(8'h20 + 4 * p), w);
            for (int k = 0; k < 4; k++) begin
                prioM[4 * p + k] = w[4 * k +: 3];
            end
        end
        for (int g = 0; g < 4; g++) begin
            w = 16'($random(seed));
            wr(8'(8'h0c + 4 * g), w);
            enM[16 * g +: 16] = (g == 3) ? (w & 16'h2100) : w;
        end
        altM = 1'($random(seed));
        wr(8'h00, {altM, 15'h0});
    endtask

    // ====================================================
    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        $display("Error at %0t ns: watchdog expired", $time);
        wrap_up();
    end

    // ====================================================
    // main sequence
    initial begin
        logic [63:0] irq;
        logic [4:0] tr;
        logic [31:0] r;
        for (int i = 0; i < 64; i++) begin
            prioM[i] = 3'h4;
        end
        enM = 64'h0;
        altM = 1'b0;
        do_reset();
        rdc(8'h00, 16'h0000, "control reset");
        for (int g = 0; g < 4; g++) begin
            rdc(8'(8'h0c + 4 * g), 16'h0000, "enable reset");
        end
        rdc(8'h20, 16'h4444, "priority reset");
        rdc(8'h5c, 16'h4444, "priority reset");
        rdc(8'h04, 16'h0000, "status reset");
        rdc(8'h08, 16'h0000, "mask reset");
        apply('1, 5'h00, 3'h0, "all disabled");
        wr(8'h18, 16'hffff);
        rdc(8'h18, 16'h2100, "group 3 bits");
        wr(8'h64, 16'hffff);
        rdc(8'h64, 16'h0000, "unmapped place");
        for (int g = 0; g < 3; g++) begin
            wr(8'(8'h0c + 4 * g), 16'hffff);
        end
        enM = {16'h2100, 48'hffff_ffff_ffff};
        for (int p = 0; p < 16; p++) begin
            wr(8'(8'h20 + 4 * p), 16'h7777);
        end
        for (int i = 0; i < 64; i++) begin
            prioM[i] = 3'h7;
        end
        apply('1, 5'h00, 3'h0, "tie to lowest slot");
        apply(64'h2000_0000_0000_0000, 5'h00, 3'h0, "last slot");
        apply('1, 5'h00, 3'h7, "core level blocks");
        apply('1, 5'h10, 3'h7, "trap over level");
        apply('1, 5'h1f, 3'h0, "vector zero first");
        wr(8'h00, 16'h8000);
        altM = 1'b1;
        apply('1, 5'h1f, 3'h0, "alternate trap");
        apply('1, 5'h00, 3'h0, "alternate irq");
        rdc(8'h60, 16'h0088, "winner readback");
        for (int it = 0; it < 48; it++) begin
            if (it % 8 == 0) begin
                program_all();
            end
            r = $random(seed);
            irq = {32'($random(seed)), 32'($random(seed))};
            tr = (r[1:0] == 2'h0) ? r[6:2] : 5'h00;
            apply(irq, tr, r[10:8], "random");
        end
        // interrupt taken, raised, then cleared by writing one
        wr(8'h0c, 16'hffff);
        wr(8'h20, 16'h7777);
        wr(8'h08, 16'h0003);
        @(posedge clock);
        irqIn <= '1;
        trapIn <= 5'h00;
        coreIpl <= 3'h0;
        ackWait <= 2'h2;
        ackOn <= 1'b1;
        wait_irq(1'b1, "irq raised on take");
        @(posedge clock);
        ackOn <= 1'b0;
        irqIn <= 64'h0;
        rdc(8'h04, 16'h0001, "taken status");
        wr(8'h04, 16'h0001);
        wait_irq(1'b0, "irq cleared");
        rdc(8'h04, 16'h0000, "status cleared");
        // trap taken with mask off: status set but no interrupt
        wr(8'h08, 16'h0000);
        @(posedge clock);
        trapIn <= 5'h04;
        ackWait <= 2'h0;
        ackOn <= 1'b1;
        repeat (10) @(posedge clock);
        ackOn <= 1'b0;
        trapIn <= 5'h00;
        rdc(8'h04, 16'h0002, "trap status");
        @(negedge clock);
        check({32'h0, irqOut}, 33'h0, "masked irq");
        wr(8'h08, 16'h0002);
        wait_irq(1'b1, "unmasked irq");
        wr(8'h04, 16'h0002);
        wait_irq(1'b0, "trap cleared");
        do_reset();
        rdc(8'h0c, 16'h0000, "enable after reset");
        rdc(8'h00, 16'h0000, "control after reset");
        wrap_up();
    end
endmodule // tb
